// >>> verilog/adc_mon_pkg.sv
// shared register map, field layout, reset values and timing for the monitor block
package adc_mon_pkg;
    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_FAULT_STATUS = 8'h01;
    localparam logic [7:0] IDX_GAIN_SETTING = 8'h03;
    localparam logic [7:0] IDX_EXCITATION_ONE = 8'h06;
    localparam logic [7:0] IDX_EXCITATION_TWO = 8'h07;
    localparam logic [7:0] IDX_SENSOR_BIASING = 8'h08;
    localparam logic [7:0] IDX_SYSTEM_CONTROL = 8'h09;
    localparam logic [7:0] IDX_AUX_CONTROL = 8'h0A;

    // field positions
    localparam int POS_POWER_ON_FLAG = 7;
    localparam int POS_READY_N = 6;
    localparam int POS_DELAY = 5;
    localparam int POS_AMP_ENABLE = 3;
    localparam int POS_GAIN = 0;
    localparam int POS_MAGNITUDE = 0;
    localparam int POS_ROUTE_ONE = 0;
    localparam int POS_ROUTE_TWO = 4;
    localparam int POS_BIAS_LEVEL = 7;
    localparam int POS_BIAS_PINS = 0;
    localparam int POS_SYS_MON = 5;
    localparam int POS_STATUS_APPEND = 0;
    localparam int POS_REF_ENABLE = 0;
    localparam int POS_CHOP_ENABLE = 1;

    // reset values
    localparam logic [7:0] RST_GAIN_SETTING = 8'h00;
    localparam logic [7:0] RST_EXCITATION_ONE = 8'h00;
    localparam logic [7:0] RST_EXCITATION_TWO = 8'hFF;
    localparam logic [7:0] RST_SENSOR_BIASING = 8'h00;
    localparam logic [7:0] RST_SYSTEM_CONTROL = 8'h00;
    localparam logic [7:0] RST_AUX_CONTROL = 8'h00;
    localparam logic [7:0] RST_FAULT_STATUS = 8'hC0;

    // system monitor codes
    localparam logic [2:0] MON_NORMAL = 3'h0;
    localparam logic [2:0] MON_NORMAL_ALT = 3'h1;
    localparam logic [2:0] MON_TEMPERATURE = 3'h2;
    localparam logic [2:0] MON_ANALOG_SUPPLY = 3'h3;
    localparam logic [2:0] MON_DIGITAL_SUPPLY = 3'h4;
    localparam logic [2:0] MON_BURN_LOW = 3'h5;
    localparam logic [2:0] MON_BURN_MID = 3'h6;
    localparam logic [2:0] MON_BURN_HIGH = 3'h7;
    localparam logic [2:0] GAIN_UNITY = 3'h0;

    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int STARTUP_TIME_NS = 2000;
    localparam int STARTUP_CYCLES = (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MOD_PERIOD_NS = 400;
    localparam int MOD_CYCLES = (MOD_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DELAY_BASE_MOD = 14;

    // burn-out current levels
    typedef enum logic [1:0]
    {
        BURN_OFF = 2'h0,
        BURN_0U2 = 2'h1,
        BURN_1U = 2'h2,
        BURN_10U = 2'h3
    } burn_level_t;

    typedef struct packed
    {
        logic temp_sel;
        logic analog_supply_sel;
        logic digital_supply_sel;
        logic inputs_disconnect;
        burn_level_t burn_level;
        logic burn_source_p;
        logic burn_sink_n;
    } monitor_route_t;
endpackage

// >>> verilog/chop_averager.sv
// pairs conversions with reversed inputs and averages them in global chop mode
`timescale 1ns/10ps
module chop_averager #(
    parameter int WIDTH = 16
) (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic chop_en, // global chop mode on
    input wire logic in_valid, // raw conversion done
    input wire logic signed [WIDTH-1:0] in_data, // raw conversion value
    output logic out_valid, // result pulse
    output logic signed [WIDTH-1:0] out_data, // result value
    output logic swap // inputs reversed for next conversion
);
    logic signed [WIDTH-1:0] first_ff;
    logic have_first_ff;
    logic signed [WIDTH:0] nxt_sum;

    // second sample was taken reversed, so its sign is flipped before adding
    always_comb
    begin
        nxt_sum = (WIDTH+1)'(first_ff) - (WIDTH+1)'(in_data);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            first_ff <= '0;
            have_first_ff <= 1'b0;
            swap <= 1'b0;
            out_valid <= 1'b0;
            out_data <= '0;
        end
        else
        begin
            out_valid <= 1'b0;
            if (!chop_en)
            begin
                have_first_ff <= 1'b0;
                swap <= 1'b0;
                if (in_valid)
                begin
                    out_valid <= 1'b1;
                    out_data <= in_data;
                end
            end
            else if (in_valid)
            begin
                swap <= ~swap;
                if (!have_first_ff)
                begin
                    first_ff <= in_data;
                    have_first_ff <= 1'b1;
                end
                else
                begin
                    // halving keeps the average inside the data width
                    have_first_ff <= 1'b0;
                    out_valid <= 1'b1; // [RL1]
                    out_data <= nxt_sum[WIDTH:1]; // [RL1]
                end
            end
        end
    end
endmodule // chop_averager

// >>> verilog/adc_monitor_status_control.sv
// register bank, monitor routing, settling delay and status handling
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/10ps
// Functional notes
// RL1 - global chop averages each reversed pair
// RL2 - start delay field lengthens settling
// RL3 - both sources share the four-bit magnitude
// RL4 - own four-bit route per source, same pin allowed
// RL5 - sources work only with internal reference on
// RL6 - level bit: bias at half or 1/12 span
// RL7 - per-pin bias enables, inputs 0..5 and common
// RL8 - host waits for bias settling before converting
// RL9 - monitor code 010 selects temperature sensor
// RL10 - temperature: inputs off, programmed gain kept
// RL11 - host keeps gain at most 4 for temperature
// RL12 - code 011 analog, 100 digital supply monitor
// RL13 - supply monitor: inputs off, unity gain
// RL14 - supply monitor with amplifier on or bypassed
// RL15 - codes 101..111: 0.2, 1, 10 uA burn-out
// RL16 - burn-out sources into P, sinks from N
// RL17 - host: chop off, burn-out for fault tests only
// RL18 - status byte readable at its own address
// RL19 - append bit puts status ahead of each result
// RL20 - faults latched per conversion, read gives latest
// RL21 - bit 7 power-on flag set by reset, held
// RL22 - power-on flag clears only by writing 0
// RL23 - bit 6 active-low ready after start-up
// RL24 - bits 5..2 rail flags, 1..0 reference-low
// RL25 - codes 000, 001 keep normal path, no source
module adc_monitor_status_control #(
    parameter int DATA_WIDTH = 16,
    parameter int ADR_WIDTH = 8
) (
    input wire logic CLK_SYS, // system clock
    input wire logic RSTN, // async power-on reset, active low
    input wire logic WB_CYC_I, // bus cycle
    input wire logic WB_STB_I, // bus strobe
    input wire logic WB_WE_I, // write enable
    input wire logic [ADR_WIDTH-1:0] WB_ADR_I, // byte address
    input wire logic [3:0] WB_SEL_I, // byte lanes
    input wire logic [31:0] WB_DAT_I, // write data
    output logic [31:0] WB_DAT_O, // read data
    output logic WB_ACK_O, // acknowledge
    input wire logic START_REQ, // conversion start request pulse
    output logic CONV_GO, // conversion begins, pulse
    input wire logic CONV_DONE, // conversion finished pulse
    input wire logic [DATA_WIDTH-1:0] CONV_DATA, // raw conversion value
    input wire logic [5:0] FAULT_IN, // rail flags [5:2], reference flags [1:0]
    output logic CHOP_SWAP, // inputs reversed
    output logic RESULT_VALID, // result frame pulse
    output logic [23:0] RESULT_FRAME, // status byte then data, or data only
    output logic RESULT_HAS_STATUS, // frame carries status byte
    output logic [3:0] SOURCE_ONE_MAG, // current source one magnitude
    output logic [3:0] SOURCE_TWO_MAG, // current source two magnitude
    output logic [3:0] SOURCE_ONE_ROUTE, // current source one pin
    output logic [3:0] SOURCE_TWO_ROUTE, // current source two pin
    output logic BIAS_LEVEL, // 1 = one twelfth span, 0 = half span
    output logic [6:0] BIAS_PINS, // bias on inputs 0..5 and common
    output logic [2:0] EFFECTIVE_GAIN, // gain code applied to amplifier
    output logic [1:0] AMP_ENABLE, // amplifier enable field
    output adc_mon_pkg::monitor_route_t MON_ROUTE, // monitor source selection
    output logic READY_N // start-up incomplete, active low ready
);
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] STARTUP_LAST = CNT_W'(adc_mon_pkg::STARTUP_CYCLES - 1);

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_SETTLE = 3'b010,
        ST_RUN = 3'b100
    } seq_t;

    logic [7:0] gain_setting_ff;
    logic [7:0] excitation_one_ff;
    logic [7:0] excitation_two_ff;
    logic [7:0] sensor_biasing_ff;
    logic [7:0] system_control_ff;
    logic [7:0] aux_control_ff;
    logic power_on_flag_ff;
    logic ready_n_ff;
    logic [5:0] fault_ff;
    logic [CNT_W-1:0] startup_cnt_ff;
    logic [CNT_W-1:0] delay_cnt_ff;
    seq_t seq_ff;
    logic ack_ff;
    logic bus_req;
    logic wr_stb;
    logic [ADR_WIDTH-3:0] word_idx;
    logic [7:0] rd_byte;
    logic [7:0] status_byte;
    logic avg_valid;
    logic signed [DATA_WIDTH-1:0] avg_data;
    logic avg_swap;
    logic [2:0] mon_code;
    logic chop_en;
    logic ref_en;

    // settling delay in system cycles: base modulator periods doubled per code step
    function automatic logic [CNT_W-1:0] delay_cycles(input logic [2:0] code);
        delay_cycles = CNT_W'((adc_mon_pkg::DELAY_BASE_MOD * adc_mon_pkg::MOD_CYCLES) << code);
    endfunction

    function automatic logic is_idx(input logic [ADR_WIDTH-3:0] idx, input logic [7:0] reg_idx);
        is_idx = (8'(idx) == reg_idx);
    endfunction

    assign bus_req = WB_CYC_I & WB_STB_I;
    assign word_idx = WB_ADR_I[ADR_WIDTH-1:2];
    // writes before start-up completes are acknowledged but dropped
    assign wr_stb = bus_req & WB_WE_I & WB_SEL_I[0] & ~ack_ff & ~ready_n_ff; // [RL23]
    assign mon_code = system_control_ff[adc_mon_pkg::POS_SYS_MON +: 3];
    assign chop_en = aux_control_ff[adc_mon_pkg::POS_CHOP_ENABLE];
    assign ref_en = aux_control_ff[adc_mon_pkg::POS_REF_ENABLE];
    assign status_byte = {power_on_flag_ff, ready_n_ff, fault_ff}; // [RL24]

    always_comb
    begin
        case (8'(word_idx))
            adc_mon_pkg::IDX_FAULT_STATUS: rd_byte = status_byte; // [RL18]
            adc_mon_pkg::IDX_GAIN_SETTING: rd_byte = gain_setting_ff;
            adc_mon_pkg::IDX_EXCITATION_ONE: rd_byte = excitation_one_ff;
            adc_mon_pkg::IDX_EXCITATION_TWO: rd_byte = excitation_two_ff;
            adc_mon_pkg::IDX_SENSOR_BIASING: rd_byte = sensor_biasing_ff;
            adc_mon_pkg::IDX_SYSTEM_CONTROL: rd_byte = system_control_ff;
            adc_mon_pkg::IDX_AUX_CONTROL: rd_byte = aux_control_ff;
            default: rd_byte = 8'h00;
        endcase
    end

    // bus answer: one wait state, ack for one cycle
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            ack_ff <= 1'b0;
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end
        else
        begin
            ack_ff <= bus_req & ~ack_ff;
            WB_ACK_O <= bus_req & ~ack_ff;
            WB_DAT_O <= {24'h00_0000, rd_byte};
        end
    end

    // configuration registers
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            gain_setting_ff <= adc_mon_pkg::RST_GAIN_SETTING;
            excitation_one_ff <= adc_mon_pkg::RST_EXCITATION_ONE;
            excitation_two_ff <= adc_mon_pkg::RST_EXCITATION_TWO;
            sensor_biasing_ff <= adc_mon_pkg::RST_SENSOR_BIASING;
            system_control_ff <= adc_mon_pkg::RST_SYSTEM_CONTROL;
            aux_control_ff <= adc_mon_pkg::RST_AUX_CONTROL;
        end
        else if (wr_stb)
        begin
            case (8'(word_idx))
                adc_mon_pkg::IDX_GAIN_SETTING: gain_setting_ff <= WB_DAT_I[7:0]; // [RL2]
                adc_mon_pkg::IDX_EXCITATION_ONE: excitation_one_ff <= WB_DAT_I[7:0];
                adc_mon_pkg::IDX_EXCITATION_TWO: excitation_two_ff <= WB_DAT_I[7:0];
                adc_mon_pkg::IDX_SENSOR_BIASING: sensor_biasing_ff <= WB_DAT_I[7:0];
                adc_mon_pkg::IDX_SYSTEM_CONTROL: system_control_ff <= WB_DAT_I[7:0];
                adc_mon_pkg::IDX_AUX_CONTROL: aux_control_ff <= WB_DAT_I[7:0];
                default: ;
            endcase
        end
    end

    // power-on flag: only reset sets it, so no set/clear race exists
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
            power_on_flag_ff <= adc_mon_pkg::RST_FAULT_STATUS[adc_mon_pkg::POS_POWER_ON_FLAG]; // [RL21]
        else if (wr_stb && is_idx(word_idx, adc_mon_pkg::IDX_FAULT_STATUS)
                 && !WB_DAT_I[adc_mon_pkg::POS_POWER_ON_FLAG])
            power_on_flag_ff <= 1'b0; // [RL22]
    end

    // start-up counter releases ready
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            startup_cnt_ff <= '0;
            ready_n_ff <= adc_mon_pkg::RST_FAULT_STATUS[adc_mon_pkg::POS_READY_N];
        end
        else if (ready_n_ff)
        begin
            startup_cnt_ff <= startup_cnt_ff + CNT_W'(1);
            if (startup_cnt_ff == STARTUP_LAST)
                ready_n_ff <= 1'b0; // [RL23]
        end
    end

    // fault flags refresh only at the end of each conversion
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
            fault_ff <= adc_mon_pkg::RST_FAULT_STATUS[5:0];
        else if (CONV_DONE)
            fault_ff <= FAULT_IN; // [RL20]
    end

    // settling delay before each conversion; chop inserts it on every one
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            seq_ff <= ST_IDLE;
            delay_cnt_ff <= '0;
            CONV_GO <= 1'b0;
        end
        else
        begin
            CONV_GO <= 1'b0;
            case (seq_ff)
                ST_IDLE:
                begin
                    if (START_REQ && !ready_n_ff)
                    begin
                        delay_cnt_ff <= delay_cycles(gain_setting_ff[adc_mon_pkg::POS_DELAY +: 3]); // [RL2]
                        seq_ff <= ST_SETTLE;
                    end
                end
                ST_SETTLE:
                begin
                    delay_cnt_ff <= delay_cnt_ff - CNT_W'(1);
                    if (delay_cnt_ff <= CNT_W'(1))
                    begin
                        CONV_GO <= 1'b1;
                        seq_ff <= ST_RUN;
                    end
                end
                ST_RUN:
                begin
                    if (CONV_DONE)
                    begin
                        // the reversed half of a chop pair needs its own settling
                        if (chop_en && !avg_swap)
                        begin
                            delay_cnt_ff <= delay_cycles(gain_setting_ff[adc_mon_pkg::POS_DELAY +: 3]); // [RL1]
                            seq_ff <= ST_SETTLE;
                        end
                        else
                            seq_ff <= ST_IDLE;
                    end
                end
                default:
                    seq_ff <= ST_IDLE;
            endcase
        end
    end

    chop_averager #(
        .WIDTH(DATA_WIDTH)
    ) u_avg (
        .clk(CLK_SYS),
        .rst_n(RSTN),
        .chop_en(chop_en),
        .in_valid(CONV_DONE),
        .in_data(CONV_DATA),
        .out_valid(avg_valid),
        .out_data(avg_data),
        .swap(avg_swap)
    );

    // result frame; status sits in the top byte when appended
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            RESULT_VALID <= 1'b0;
            RESULT_FRAME <= 24'h00_0000;
            RESULT_HAS_STATUS <= 1'b0;
            CHOP_SWAP <= 1'b0;
        end
        else
        begin
            CHOP_SWAP <= avg_swap;
            RESULT_VALID <= avg_valid; // [RL1]
            if (avg_valid)
            begin
                RESULT_HAS_STATUS <= system_control_ff[adc_mon_pkg::POS_STATUS_APPEND]; // [RL19]
                if (system_control_ff[adc_mon_pkg::POS_STATUS_APPEND])
                    RESULT_FRAME <= {status_byte, avg_data}; // [RL19]
                else
                    RESULT_FRAME <= {8'h00, avg_data};
            end
        end
    end

    // analog steering outputs, registered from the configuration
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            SOURCE_ONE_MAG <= 4'h0;
            SOURCE_TWO_MAG <= 4'h0;
            SOURCE_ONE_ROUTE <= 4'hF;
            SOURCE_TWO_ROUTE <= 4'hF;
            BIAS_LEVEL <= 1'b0;
            BIAS_PINS <= 7'h00;
            AMP_ENABLE <= 2'h0;
            READY_N <= 1'b1;
        end
        else
        begin
            // sources stay off without the internal reference
            SOURCE_ONE_MAG <= ref_en ? excitation_one_ff[adc_mon_pkg::POS_MAGNITUDE +: 4] : 4'h0; // [RL3] [RL5]
            SOURCE_TWO_MAG <= ref_en ? excitation_one_ff[adc_mon_pkg::POS_MAGNITUDE +: 4] : 4'h0; // [RL3] [RL5]
            SOURCE_ONE_ROUTE <= excitation_two_ff[adc_mon_pkg::POS_ROUTE_ONE +: 4]; // [RL4]
            SOURCE_TWO_ROUTE <= excitation_two_ff[adc_mon_pkg::POS_ROUTE_TWO +: 4]; // [RL4]
            BIAS_LEVEL <= sensor_biasing_ff[adc_mon_pkg::POS_BIAS_LEVEL]; // [RL6]
            BIAS_PINS <= sensor_biasing_ff[adc_mon_pkg::POS_BIAS_PINS +: 7]; // [RL7]
            AMP_ENABLE <= gain_setting_ff[adc_mon_pkg::POS_AMP_ENABLE +: 2]; // [RL14]
            READY_N <= ready_n_ff;
        end
    end

    // system monitor decode
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            MON_ROUTE <= '0;
            EFFECTIVE_GAIN <= adc_mon_pkg::GAIN_UNITY;
        end
        else
        begin
            MON_ROUTE <= '0; // [RL25]
            EFFECTIVE_GAIN <= gain_setting_ff[adc_mon_pkg::POS_GAIN +: 3]; // [RL10]
            case (mon_code)
                adc_mon_pkg::MON_TEMPERATURE:
                begin
                    MON_ROUTE.temp_sel <= 1'b1; // [RL9]
                    MON_ROUTE.inputs_disconnect <= 1'b1; // [RL10]
                end
                adc_mon_pkg::MON_ANALOG_SUPPLY:
                begin
                    MON_ROUTE.analog_supply_sel <= 1'b1; // [RL12]
                    MON_ROUTE.inputs_disconnect <= 1'b1; // [RL13]
                    EFFECTIVE_GAIN <= adc_mon_pkg::GAIN_UNITY; // [RL13]
                end
                adc_mon_pkg::MON_DIGITAL_SUPPLY:
                begin
                    MON_ROUTE.digital_supply_sel <= 1'b1; // [RL12]
                    MON_ROUTE.inputs_disconnect <= 1'b1; // [RL13]
                    EFFECTIVE_GAIN <= adc_mon_pkg::GAIN_UNITY; // [RL13]
                end
                adc_mon_pkg::MON_BURN_LOW, adc_mon_pkg::MON_BURN_MID,
                adc_mon_pkg::MON_BURN_HIGH:
                begin
                    MON_ROUTE.burn_level <= adc_mon_pkg::burn_level_t'(mon_code[1:0]); // [RL15]
                    MON_ROUTE.burn_source_p <= 1'b1; // [RL16]
                    MON_ROUTE.burn_sink_n <= 1'b1; // [RL16]
                end
                default:
                    MON_ROUTE <= '0; // [RL25]
            endcase
        end
    end
endmodule // adc_monitor_status_control

// >>> tb/adc_mon_chk.sv
// concurrent checks on the ports of the monitor register block
`timescale 1ns/10ps
module adc_mon_chk (
    input wire logic CLK_SYS, // clock
    input wire logic RSTN, // reset
    input wire logic WB_CYC_I, // cycle
    input wire logic WB_STB_I, // strobe
    input wire logic WB_ACK_O, // ack
    input wire logic CONV_GO, // start pulse
    input wire logic RESULT_VALID, // result pulse
    input wire logic [23:0] RESULT_FRAME, // frame
    input wire logic RESULT_HAS_STATUS, // status in frame
    input wire logic [3:0] SOURCE_ONE_MAG, // mag one
    input wire logic [3:0] SOURCE_TWO_MAG, // mag two
    input wire logic [2:0] EFFECTIVE_GAIN, // gain
    input wire adc_mon_pkg::monitor_route_t MON_ROUTE, // route
    input wire logic READY_N // ready
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    sequence bus_req;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    sequence ack_once;
        WB_ACK_O ##1 !WB_ACK_O;
    endsequence
    bus_ack_a: assert property (bus_req |=> ack_once)
        else $error("ack not a one-cycle pulse");
    mag_match_a: assert property (SOURCE_ONE_MAG == SOURCE_TWO_MAG)
        else $error("magnitudes differ");
    supply_gain_a: assert property ((MON_ROUTE.analog_supply_sel || MON_ROUTE.digital_supply_sel)
        |-> EFFECTIVE_GAIN == 3'h0 && MON_ROUTE.inputs_disconnect)
        else $error("supply mode gain or path wrong");
    temp_path_a: assert property (MON_ROUTE.temp_sel |-> MON_ROUTE.inputs_disconnect
        && MON_ROUTE.burn_level == adc_mon_pkg::BURN_OFF) else $error("temperature path wrong");
    burn_pair_a: assert property (MON_ROUTE.burn_level != adc_mon_pkg::BURN_OFF
        |-> MON_ROUTE.burn_source_p && MON_ROUTE.burn_sink_n) else $error("burn pair incomplete");
    go_pulse_a: assert property ($rose(CONV_GO) |=> !CONV_GO)
        else $error("start pulse too long");
    frame_pad_a: assert property (RESULT_VALID && !RESULT_HAS_STATUS
        |-> RESULT_FRAME[23:16] == 8'h00) else $error("frame not padded");
    ready_hold_a: assert property (!READY_N |=> !READY_N)
        else $error("ready lost");
endmodule // adc_mon_chk
bind adc_monitor_status_control adc_mon_chk adc_mon_chk_inst (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .CONV_GO(CONV_GO),
    .RESULT_VALID(RESULT_VALID), .RESULT_FRAME(RESULT_FRAME),
    .RESULT_HAS_STATUS(RESULT_HAS_STATUS), .SOURCE_ONE_MAG(SOURCE_ONE_MAG),
    .SOURCE_TWO_MAG(SOURCE_TWO_MAG), .EFFECTIVE_GAIN(EFFECTIVE_GAIN), .MON_ROUTE(MON_ROUTE),
    .READY_N(READY_N));

// >>> tb/conv_model.sv
// behavioural converter answering conversion starts
`timescale 1ns/10ps
module conv_model (
    input wire logic clk, // clock
    input wire logic go, // start
    input wire logic swap, // reversed inputs
    input wire logic [15:0] x, // signal part
    input wire logic [15:0] e, // offset part
    input wire logic [5:0] flt, // faults
    input wire logic [7:0] lat, // finish latency
    output logic done, // finish pulse
    output logic [15:0] data, // reading
    output logic [5:0] fault // fault lines
);
    logic s;
    initial
    begin
        done = 1'h0;
        data = 16'h0;
        fault = 6'h0;
        forever
        begin
            @(posedge clk);
            if (go === 1'h1)
            begin
                s = swap;
                repeat (lat) @(posedge clk);
                done <= 1'h1;
                data <= s ? e - x : e + x; // reversal negates signal, not offset
                fault <= flt;
                @(posedge clk);
                done <= 1'h0;
                data <= ~data; // stale reading must not look valid
                fault <= ~fault;
            end
        end
    end
endmodule // conv_model

// >>> tb/adc_monitor_status_control_tb.sv
// self-checking bench for the monitor register block
`timescale 1ns/10ps
module adc_monitor_status_control_tb;
    logic clk, ack, go, swap, rv, hs, blev, rdyn, done;
    logic rstn = 1'h0, req = 1'h0, we = 1'h0, start = 1'h0;
    logic [7:0] adr = 8'h0, lat = 8'h1, q;
    logic [31:0] wdat = 32'h0, rdat;
    logic [15:0] r = 16'hCACB, x = 16'h0, e = 16'h0, cdata;
    logic [5:0] flt = 6'h0, fin;
    logic [3:0] m1, m2, r1, r2;
    logic [6:0] pins;
    logic [2:0] gain;
    logic [1:0] amp;
    logic [23:0] frame;
    adc_mon_pkg::monitor_route_t route;
    int failures = 0, compares = 0, n;
    adc_monitor_status_control adc_monitor_status_control_inst (.CLK_SYS(clk), .RSTN(rstn),
        .WB_CYC_I(req), .WB_STB_I(req), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
        .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .START_REQ(start), .CONV_GO(go),
        .CONV_DONE(done), .CONV_DATA(cdata), .FAULT_IN(fin), .CHOP_SWAP(swap),
        .RESULT_VALID(rv), .RESULT_FRAME(frame), .RESULT_HAS_STATUS(hs),
        .SOURCE_ONE_MAG(m1), .SOURCE_TWO_MAG(m2), .SOURCE_ONE_ROUTE(r1),
        .SOURCE_TWO_ROUTE(r2), .BIAS_LEVEL(blev), .BIAS_PINS(pins), .EFFECTIVE_GAIN(gain),
        .AMP_ENABLE(amp), .MON_ROUTE(route), .READY_N(rdyn));
    conv_model conv_model_inst (.clk(clk), .go(go), .swap(swap), .x(x), .e(e), .flt(flt),
        .lat(lat), .done(done), .data(cdata), .fault(fin));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [7:0] route_exp(input logic [2:0] m);
        return {m == 3'h2, m == 3'h3, m == 3'h4, m inside {[3'h2:3'h4]},
            m > 3'h4 ? {m[1:0], 2'h3} : 4'h0};
    endfunction
    task automatic final_report;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [23:0] ex, input logic [23:0] got);
        compares++;
        if (got !== ex)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic tmo(input int k, input int lim);
        if (k >= lim)
            chk("timeout", 24'h0, 24'h1);
        if (k >= lim)
            final_report();
    endtask
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int k;
        @(posedge clk);
        req <= 1'h1;
        we <= w;
        adr <= {idx[5:0], 2'h0};
        wdat <= {24'h0, d};
        for (k = 0; k < 20 && !(k > 0 && ack === 1'h1); k++) @(posedge clk);
        q = rdat[7:0];
        req <= 1'h0;
        tmo(k, 20);
    endtask
    task automatic conv(input logic c, input logic a, input logic [2:0] dl, input logic [7:0] l);
        logic [15:0] ex;
        int k;
        r = lfsr(r);
        x <= {{7{r[8]}}, r[8:0]};
        e <= {{5{r[15]}}, r[15:5]};
        flt <= r[5:0];
        lat <= l;
        wb(1'h1, 8'h0A, {6'h0, c, 1'h1});
        wb(1'h1, 8'h09, {7'h0, a});
        wb(1'h1, 8'h03, {dl, 5'h0A});
        start <= 1'h1;
        @(posedge clk);
        start <= 1'h0;
        for (k = 0; k < 2000 && go !== 1'h1; k++) @(posedge clk);
        tmo(k, 2000);
        chk("delay", 24'h1, 24'(k >= (56 << dl) && k <= (56 << dl) + 3));
        ex = c ? (swap ? -x : x) : (swap ? e - x : e + x);
        for (k = 0; k < 3000 && rv !== 1'h1; k++) @(posedge clk);
        tmo(k, 3000);
        chk("frame", {a ? {2'h0, flt} : 8'h0, ex}, frame);
        wb(1'h0, 8'h01, 8'h0);
        chk("status", {2'h0, flt}, q);
        $display("conversion test done chop %0d", c);
    endtask
    initial
    begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        repeat (4) @(posedge clk);
        rstn <= 1'h1;
        wb(1'h0, 8'h01, 8'h0);
        chk("por", 8'hC0, q);
        for (n = 0; n < 100 && rdyn !== 1'h0; n++) @(posedge clk);
        tmo(n, 100);
        wb(1'h0, 8'h01, 8'h0);
        chk("ready", 8'h80, q);
        wb(1'h0, 8'h07, 8'h0);
        chk("reset_route", 8'hFF, q);
        wb(1'h0, 8'h3F, 8'h0);
        chk("unmapped", 8'h0, q);
        wb(1'h1, 8'h01, 8'hFF);
        wb(1'h0, 8'h01, 8'h0);
        chk("por_keep", 8'h80, q);
        wb(1'h1, 8'h01, 8'h00);
        wb(1'h0, 8'h01, 8'h0);
        chk("por_clear", 8'h00, q);
        $display("status test done");
        for (n = 0; n < 6; n++)
        begin
            r = lfsr(r);
            wb(1'h1, 8'h0A, {7'h0, n[0]});
            wb(1'h1, 8'h06, r[7:0]);
            wb(1'h1, 8'h07, r[15:8]);
            wb(1'h1, 8'h08, r[7:0] ^ r[15:8]);
            repeat (2) @(posedge clk);
            chk("mag", n[0] ? {r[3:0], r[3:0]} : 8'h0, {m1, m2});
            chk("route", r[15:8], {r2, r1});
            chk("bias", r[7:0] ^ r[15:8], {blev, pins});
        end
        wb(1'h1, 8'h03, 8'h0A); // amplifier on, modest gain for the temperature sensor
        for (n = 0; n < 8; n++)
        begin
            wb(1'h1, 8'h09, {n[2:0], 5'h0}); // chop is off here for the burn-out codes
            repeat (2) @(posedge clk);
            chk("mon", route_exp(n[2:0]), route);
            chk("gain", (n == 3 || n == 4) ? 3'h0 : 3'h2, gain);
            chk("amp", 2'h1, amp);
        end
        $display("monitor test done");
        repeat (2800) @(posedge clk); // bias settles for a 0.1 uF load
        conv(1'h0, 1'h1, 3'h0, 8'h1);
        conv(1'h1, 1'h0, 3'h1, 8'h1E);
        conv(1'h1, 1'h1, 3'h0, 8'h3);
        final_report();
    end
endmodule // adc_monitor_status_control_tb
